//--- ulf_pkg.sv
package ulf_pkg;

    // Register offsets
    localparam logic [3:0] ULF_OFS_LINE_FMT  = 4'h0;
    localparam logic [3:0] ULF_OFS_IRQ_EN    = 4'h1;
    localparam logic [3:0] ULF_OFS_BAUD_HI   = 4'h2;
    localparam logic [3:0] ULF_OFS_BAUD_LO   = 4'h3;
    localparam logic [3:0] ULF_OFS_DATA      = 4'h4;
    localparam logic [3:0] ULF_OFS_STATUS    = 4'h5;
    localparam logic [3:0] ULF_OFS_EVT       = 4'h6;
    localparam logic [3:0] ULF_OFS_EVT_MASK  = 4'h7;
    localparam logic [3:0] ULF_OFS_AUX       = 4'h8;

    // Field positions of line_format_control
    localparam int ULF_B_LOOP   = 7;
    localparam int ULF_B_WSTOP  = 6;
    localparam int ULF_B_RECEIVER_SOURCE_SELECT   = 5;
    localparam int ULF_B_NINE   = 4;
    localparam int ULF_B_WAKE   = 3;
    localparam int ULF_B_ILT    = 2;
    localparam int ULF_B_PAR    = 1;
    localparam int ULF_B_ODD    = 0;

    // Field positions of irq_and_enable_control
    localparam int ULF_B_TIE    = 7;
    localparam int ULF_B_TX_DONE_IRQ_ENABLE   = 6;
    localparam int ULF_B_TE     = 3;
    localparam int ULF_B_RE     = 2;
    localparam int ULF_B_RWU    = 1;

    // Field positions of the aux register
    localparam int ULF_B_DIR    = 0;
    localparam int ULF_B_TX9    = 1;
    localparam int ULF_B_RX9    = 2;

    // Event bits of status and mask
    localparam int ULF_E_TXDONE = 0;
    localparam int ULF_E_RXCHAR = 1;
    localparam int ULF_E_PARITY = 2;
    localparam int ULF_E_FRAME  = 3;
    localparam int ULF_E_IDLE   = 4;
    localparam int ULF_NEVT     = 5;

    // Reset values
    localparam logic [7:0]  ULF_RST_LINE_FMT = 8'h00;
    localparam logic [7:0]  ULF_RST_IRQ_EN   = 8'h00;
    localparam logic [12:0] ULF_RST_BAUD     = 13'h0004;
    localparam logic [7:0]  ULF_RST_AUX      = 8'h00;

    // Timing: sixteen sub-ticks per bit
    localparam logic [3:0]  ULF_SUB_LAST     = 4'hF;
    localparam logic [3:0]  ULF_SUB_MID      = 4'h7;
    localparam logic [3:0]  ULF_BITS_8       = 4'hA;
    localparam logic [3:0]  ULF_BITS_9       = 4'hB;
    localparam logic [3:0]  ULF_IDLE_8       = 4'hA;
    localparam logic [3:0]  ULF_IDLE_9       = 4'hB;

    // Character format, latched at character boundaries
    typedef struct packed {
        logic loop_select;
        logic receiver_source_select;
        logic nine_bit;
        logic parity_on;
        logic parity_odd_select;
    } ulf_fmt_s;

    typedef enum logic [1:0] {
        ULF_TX_IDLE,
        ULF_TX_SHIFT
    } ulf_tx_e;

    typedef enum logic [1:0] {
        ULF_RX_IDLE,
        ULF_RX_START,
        ULF_RX_DATA,
        ULF_RX_STOP
    } ulf_rx_e;

endpackage

//--- ulf_top.sv
// Behaviour
// - Loop select routes transmitter into receiver unless single-wire with direction clear
// - Loop clear: separate receive and transmit pins
// - Wait stop bit freezes logic in wait
// - Receiver source ignored unless loop select
// - Internal loopback uses neither pin
// - Single-wire: transmit pin feeds both ends
// - Eight-bit frame: start, LSB first, stop
// - Nine-bit frame adds ninth data bit
// - Wake bit picks idle or address wakeup
// - Idle count starts after start/stop bit
// - Parity enable replaces MSB with parity
// - Parity type selects even or odd
// - Transmit-empty enable requests interrupt
// - Transmit-done enable requests interrupt
// - Second control register accessible any time
// - Bit rate is clock over sixteen divisor
// - Loopback releases transmit pin
// - Direction bit steers single-wire pin
`timescale 1ns/10ps
module ulf_top
    import ulf_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       cpu_wait_i,
    input  wire logic       rxd_i,
    input  wire logic       txd_pin_i,
    output logic            txd_o,
    output logic            txd_oe_o,
    output logic            irq_o
);

    // Software registers
    logic [7:0]          fmt_reg_q;      // line_format_control
    logic [7:0]          ctl_reg_q;      // irq_and_enable_control
    logic [4:0]          baud_hi_buf_q;  // Buffered high five bits of divisor
    logic [12:0]         baud_div_q;     // Working divisor
    logic [7:0]          aux_q;          // Direction and ninth bits
    logic [7:0]          tx_buf_q;       // Transmit data buffer
    logic [8:0]          rx_buf_q;       // Received character
    logic [ULF_NEVT-1:0] evt_q;          // Sticky events
    logic [ULF_NEVT-1:0] evt_mask_q;     // Event mask
    logic                tx_buffer_empty_flag_q;         // tx_buffer_empty_flag
    logic                tc_q;           // tx_done_flag
    logic                rx_full_q;      // Receive buffer full
    logic                rwu_q;          // Receiver standby
    ulf_fmt_s            fmt_q;          // Active format

    // Datapath state
    logic [12:0] baud_cnt_q;
    ulf_tx_e     tx_st_q;
    logic [3:0]  tx_sub_q;
    logic [3:0]  tx_left_q;
    logic [10:0] tx_sh_q;
    ulf_rx_e     rx_st_q;
    logic [3:0]  rx_sub_q;
    logic [3:0]  rx_cnt_q;
    logic [8:0]  rx_sh_q;
    logic [3:0]  idle_sub_q;
    logic [3:0]  idle_cnt_q;
    logic        idle_armed_q;
    logic        rxd_s1_q, rxd_s2_q;     // Receive pin synchroniser
    logic        pin_s1_q, pin_s2_q;     // Shared pin synchroniser

    // Address decode
    wire sel_fmt  = (addr_i == ULF_OFS_LINE_FMT);
    wire sel_ctl  = (addr_i == ULF_OFS_IRQ_EN);
    wire sel_bhi  = (addr_i == ULF_OFS_BAUD_HI);
    wire sel_blo  = (addr_i == ULF_OFS_BAUD_LO);
    wire sel_data = (addr_i == ULF_OFS_DATA);
    wire sel_stat = (addr_i == ULF_OFS_STATUS);
    wire sel_evt  = (addr_i == ULF_OFS_EVT);
    wire sel_msk  = (addr_i == ULF_OFS_EVT_MASK);
    wire sel_aux  = (addr_i == ULF_OFS_AUX);
    wire wr_data  = wr_i & sel_data;
    wire rd_data  = rd_i & sel_data;

    // Control fields
    wire tx_en = ctl_reg_q[ULF_B_TE];
    wire rx_en = ctl_reg_q[ULF_B_RE];
    wire wake_addr = fmt_reg_q[ULF_B_WAKE];
    wire ilt_stop  = fmt_reg_q[ULF_B_ILT];
    wire dir_out   = aux_q[ULF_B_DIR];

    wire run = ~(cpu_wait_i & fmt_reg_q[ULF_B_WSTOP]);

    wire baud_on = run & (baud_div_q != 13'h0000) & (tx_en | rx_en);
    wire tick    = baud_on & (baud_cnt_q >= (baud_div_q - 13'h0001));

    // Transmit line, idle high
    wire tx_line = (tx_st_q == ULF_TX_SHIFT) ? tx_sh_q[0] : 1'b1;

    wire single = fmt_q.loop_select & fmt_q.receiver_source_select;
    wire rx_line = ~fmt_q.loop_select ? rxd_s2_q :
                   (single & ~dir_out) ? pin_s2_q : tx_line;

    wire oe_d = tx_en & (~fmt_q.loop_select | (single & dir_out));

    wire par7 = (^tx_buf_q[6:0]) ^ fmt_q.parity_odd_select;
    wire par8 = (^tx_buf_q) ^ fmt_q.parity_odd_select;
    wire [7:0] tx_d8 = (fmt_q.parity_on & ~fmt_q.nine_bit) ? {par7, tx_buf_q[6:0]} : tx_buf_q;
    wire tx_b9 = fmt_q.parity_on ? par8 : aux_q[ULF_B_TX9];

    wire [10:0] tx_frame = fmt_q.nine_bit ? {1'b1, tx_b9, tx_d8, 1'b0} :
                                            {2'b11, tx_d8, 1'b0};
    wire tx_load = (tx_st_q == ULF_TX_IDLE) & tx_en & ~tx_buffer_empty_flag_q & tick;
    wire tx_end  = (tx_st_q == ULF_TX_SHIFT) & tick &
                   (tx_sub_q == ULF_SUB_LAST) & (tx_left_q == 4'h1);

    // Receive word aligned to bit 0
    wire [8:0] rx_word = fmt_q.nine_bit ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    wire rx_msb   = fmt_q.nine_bit ? rx_word[8] : rx_word[7];
    wire rx_done  = (rx_st_q == ULF_RX_STOP) & tick & (rx_sub_q == ULF_SUB_LAST);
    wire par_bad  = fmt_q.parity_on & ((^rx_word) != fmt_q.parity_odd_select);
    wire addr_wake = rwu_q & wake_addr & rx_msb;
    wire rx_store = rx_done & (~rwu_q | addr_wake);

    wire [3:0] idle_need = fmt_q.nine_bit ? ULF_IDLE_9 : ULF_IDLE_8;
    wire idle_hold = ilt_stop & (rx_st_q != ULF_RX_IDLE);
    wire idle_hit  = rx_en & idle_armed_q & (idle_cnt_q == idle_need);

    // Event sources
    logic [ULF_NEVT-1:0] evt_set;
    assign evt_set[ULF_E_TXDONE] = tx_end & tx_buffer_empty_flag_q;
    assign evt_set[ULF_E_RXCHAR] = rx_store;
    assign evt_set[ULF_E_PARITY] = rx_store & par_bad;
    assign evt_set[ULF_E_FRAME]  = rx_store & ~rx_line;
    assign evt_set[ULF_E_IDLE]   = idle_hit;

    // Event clear by writing ones
    wire [ULF_NEVT-1:0] evt_clr = (wr_i & sel_evt) ? wdata_i[ULF_NEVT-1:0] : '0;

    wire irq_d = (ctl_reg_q[ULF_B_TIE] & tx_buffer_empty_flag_q) | (ctl_reg_q[ULF_B_TX_DONE_IRQ_ENABLE] & tc_q) |
                 (|(evt_q & evt_mask_q));

    // Status readout
    wire [7:0] stat_rd = {tx_buffer_empty_flag_q, tc_q, rx_full_q, rwu_q, 1'b0,
                          tx_st_q == ULF_TX_SHIFT, rx_st_q != ULF_RX_IDLE, idle_armed_q};
    wire [7:0] aux_rd  = {5'h00, rx_buf_q[8], aux_q[ULF_B_TX9], aux_q[ULF_B_DIR]};

    wire [7:0] rd_mux = sel_fmt  ? fmt_reg_q :
                        sel_ctl  ? ctl_reg_q :
                        sel_bhi  ? {3'h0, baud_div_q[12:8]} :
                        sel_blo  ? baud_div_q[7:0] :
                        sel_data ? rx_buf_q[7:0] :
                        sel_stat ? stat_rd :
                        sel_evt  ? {3'h0, evt_q} :
                        sel_msk  ? {3'h0, evt_mask_q} :
                        sel_aux  ? aux_rd : 8'h00;

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= rxd_i;
            rxd_s2_q <= rxd_s1_q;
            pin_s1_q <= txd_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Register writes and read data
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fmt_reg_q     <= ULF_RST_LINE_FMT;
            ctl_reg_q     <= ULF_RST_IRQ_EN;
            baud_hi_buf_q <= ULF_RST_BAUD[12:8];
            baud_div_q    <= ULF_RST_BAUD;
            aux_q         <= ULF_RST_AUX;
            evt_mask_q    <= '0;
            rdata_o       <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
            if (wr_i & sel_fmt) begin
                fmt_reg_q <= wdata_i;
            end
            if (wr_i & sel_ctl) begin
                ctl_reg_q <= wdata_i;
            end else if ((rx_done & addr_wake) | (idle_hit & ~wake_addr & rwu_q)) begin
                ctl_reg_q[ULF_B_RWU] <= 1'b0;
            end
            if (wr_i & sel_bhi) begin
                baud_hi_buf_q <= wdata_i[4:0];
            end
            // divisor takes effect on low write
            if (wr_i & sel_blo) begin
                baud_div_q <= {baud_hi_buf_q, wdata_i};
            end
            if (wr_i & sel_aux) begin
                aux_q <= {6'h00, wdata_i[ULF_B_TX9], wdata_i[ULF_B_DIR]};
            end
            if (wr_i & sel_msk) begin
                evt_mask_q <= wdata_i[ULF_NEVT-1:0];
            end
        end
    end

    assign rwu_q = ctl_reg_q[ULF_B_RWU];

    // Sticky events, set beats clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            evt_q <= '0;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    // Baud sub-tick generator
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            baud_cnt_q <= 13'h0000;
        end else if (!baud_on || tick) begin
            baud_cnt_q <= 13'h0000;
        end else begin
            baud_cnt_q <= baud_cnt_q + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fmt_q <= '0;
        end else if (tx_st_q == ULF_TX_IDLE && rx_st_q == ULF_RX_IDLE) begin
            fmt_q <= '{loop_select: fmt_reg_q[ULF_B_LOOP],
                       receiver_source_select: fmt_reg_q[ULF_B_RECEIVER_SOURCE_SELECT],
                       nine_bit: fmt_reg_q[ULF_B_NINE],
                       parity_on: fmt_reg_q[ULF_B_PAR],
                       parity_odd_select: fmt_reg_q[ULF_B_ODD]};
        end
    end

    // Transmit buffer and flags
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_buf_q <= 8'h00;
            tx_buffer_empty_flag_q   <= 1'b1;
            tc_q     <= 1'b1;
        end else begin
            if (wr_data) begin
                tx_buf_q <= wdata_i;
                tx_buffer_empty_flag_q   <= 1'b0;
                tc_q     <= 1'b0;
            end else begin
                // Buffer moves to shifter
                if (tx_load) begin
                    tx_buffer_empty_flag_q <= 1'b1;
                end
                // Done only when nothing is queued
                if (tx_end & tx_buffer_empty_flag_q) begin
                    tc_q <= 1'b1;
                end
            end
        end
    end

    // Transmit shifter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_st_q   <= ULF_TX_IDLE;
            tx_sub_q  <= 4'h0;
            tx_left_q <= 4'h0;
            tx_sh_q   <= '1;
        end else if (tick) begin
            case (tx_st_q)
                ULF_TX_IDLE: begin
                    if (tx_load) begin
                        tx_st_q   <= ULF_TX_SHIFT;
                        tx_sh_q   <= tx_frame;
                        tx_sub_q  <= 4'h0;
                        tx_left_q <= fmt_q.nine_bit ? ULF_BITS_9 : ULF_BITS_8;
                    end
                end
                ULF_TX_SHIFT: begin
                    tx_sub_q <= tx_sub_q + 4'h1;
                    // Bit boundary: shift LSB first
                    if (tx_sub_q == ULF_SUB_LAST) begin
                        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                        tx_left_q <= tx_left_q - 4'h1;
                        if (tx_left_q == 4'h1) begin
                            tx_st_q <= ULF_TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_q <= ULF_TX_IDLE;
                end
            endcase
        end
    end

    // Receive shifter, samples mid bit
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_st_q  <= ULF_RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_sh_q  <= 9'h000;
        end else if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            case (rx_st_q)
                ULF_RX_IDLE: begin
                    rx_sub_q <= 4'h0;
                    if (rx_en && !rx_line) begin
                        rx_st_q <= ULF_RX_START;
                    end
                end
                ULF_RX_START: begin
                    // False start filtered at mid bit
                    if (rx_sub_q == ULF_SUB_MID) begin
                        rx_sub_q <= 4'h0;
                        rx_cnt_q <= 4'h0;
                        rx_st_q  <= rx_line ? ULF_RX_IDLE : ULF_RX_DATA;
                    end
                end
                ULF_RX_DATA: begin
                    if (rx_sub_q == ULF_SUB_LAST) begin
                        rx_sh_q  <= {rx_line, rx_sh_q[8:1]};
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == (fmt_q.nine_bit ? 4'h8 : 4'h7)) begin
                            rx_st_q <= ULF_RX_STOP;
                        end
                    end
                end
                ULF_RX_STOP: begin
                    if (rx_sub_q == ULF_SUB_LAST) begin
                        rx_st_q <= ULF_RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= ULF_RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_buf_q  <= 9'h000;
            rx_full_q <= 1'b0;
        end else begin
            // New character beats read clear
            if (rx_store) begin
                rx_buf_q  <= rx_word;
                rx_full_q <= 1'b1;
            end else if (rd_data) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idle_sub_q   <= 4'h0;
            idle_cnt_q   <= 4'h0;
            idle_armed_q <= 1'b0;
        end else if (tick) begin
            idle_sub_q <= idle_sub_q + 4'h1;
            if (!rx_line || idle_hold) begin
                idle_sub_q <= 4'h0;
                idle_cnt_q <= 4'h0;
            end else if (idle_sub_q == ULF_SUB_LAST && idle_cnt_q != idle_need) begin
                idle_cnt_q <= idle_cnt_q + 4'h1;
            end
            // One idle report per gap after traffic
            if (rx_done) begin
                idle_armed_q <= 1'b1;
            end else if (idle_hit) begin
                idle_armed_q <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            txd_o    <= 1'b1;
            txd_oe_o <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            txd_o    <= tx_line;
            txd_oe_o <= oe_d;
            irq_o    <= irq_d;
        end
    end

endmodule

//--- ulf_properties.sv
`timescale 1ns/10ps
module ulf_properties
    import ulf_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       cpu_wait_i,
    input  wire logic       rxd_i,
    input  wire logic       txd_pin_i,
    input  wire logic       txd_o,
    input  wire logic       txd_oe_o,
    input  wire logic       irq_o
);
    logic [7:0] fmt_q;  // Format copy
    logic [7:0] ctl_q;  // Enable copy
    logic [4:0] msk_q;  // Mask copy
    logic       dir_q;  // Direction copy
    wire        nm = !fmt_q[ULF_B_LOOP];                      // Two-pin mode
    wire        lb = fmt_q[ULF_B_LOOP] && !fmt_q[ULF_B_RECEIVER_SOURCE_SELECT]; // Internal loop
    wire        sw = fmt_q[ULF_B_LOOP] && fmt_q[ULF_B_RECEIVER_SOURCE_SELECT];  // Shared wire
    wire        te = ctl_q[ULF_B_TE];                         // Transmitter on

    // Copies of software writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fmt_q <= 8'h00;
            ctl_q <= 8'h00;
            msk_q <= 5'h00;
            dir_q <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == ULF_OFS_LINE_FMT) fmt_q <= wdata_i;
            if (addr_i == ULF_OFS_IRQ_EN) ctl_q <= wdata_i;
            if (addr_i == ULF_OFS_EVT_MASK) msk_q <= wdata_i[4:0];
            if (addr_i == ULF_OFS_AUX) dir_q <= wdata_i[ULF_B_DIR];
        end
    end

    default clocking dck @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Routing judged after two steady edges
    pin_two_a: assert property (nm && $past(nm) && $past(nm, 2) |-> txd_oe_o == $past(te))
        else $error("Two-pin enable wrong");
    pin_loop_a: assert property (lb && $past(lb) && $past(lb, 2) |-> !txd_oe_o)
        else $error("Loop pin driven");
    pin_wire_a: assert property (sw && $past(sw) && $past(sw, 2)
        |-> txd_oe_o == ($past(dir_q) && $past(te)))
        else $error("Shared-wire enable wrong");
    wait_hold_a: assert property (cpu_wait_i && fmt_q[ULF_B_WSTOP] |=> $stable(txd_o))
        else $error("Pin moved while frozen");
    tie_irq_a: assert property (rd_i && addr_i == ULF_OFS_STATUS && ctl_q[ULF_B_TIE]
        && !cpu_wait_i ##1 rdata_o[7] |-> irq_o)
        else $error("No empty interrupt");
    tc_irq_a: assert property (rd_i && addr_i == ULF_OFS_STATUS && ctl_q[ULF_B_TX_DONE_IRQ_ENABLE]
        && !cpu_wait_i ##1 rdata_o[6] |-> irq_o)
        else $error("No done interrupt");
    irq_cause_a: assert property (irq_o && !$past(cpu_wait_i)
        |-> $past(ctl_q[ULF_B_TIE] || ctl_q[ULF_B_TX_DONE_IRQ_ENABLE] || (|msk_q)))
        else $error("Interrupt without source");
    ctl_read_a: assert property (rd_i && addr_i == ULF_OFS_IRQ_EN
        |=> {rdata_o[7:6], rdata_o[3:2]} == {ctl_q[7:6], ctl_q[3:2]})
        else $error("Enable readback wrong");
    fmt_read_a: assert property (rd_i && addr_i == ULF_OFS_LINE_FMT |=> rdata_o == fmt_q)
        else $error("Format readback wrong");
endmodule
bind ulf_top ulf_properties u_props (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .cpu_wait_i, .rxd_i, .txd_pin_i, .txd_o, .txd_oe_o, .irq_o);

//--- ulf_peer.sv
`timescale 1ns/10ps
module ulf_peer #(
    parameter int BITC = 16  // Clocks per bit at divisor one
) (
    input  wire logic       clk_i,
    input  wire logic       line_i,
    input  wire logic       nine_i,
    input  wire logic       send_i,
    input  wire logic [8:0] word_i,
    output logic            rxd_o,
    output logic [9:0]      got_o,
    output int              cnt_o
);
    // Listener samples mid-bit; stop bit lands on top
    // frame layout
    initial begin
        cnt_o = 0;
        got_o = 10'h000;
        forever begin
            @(negedge line_i);
            got_o = 10'h000;
            repeat (BITC + BITC / 2) @(posedge clk_i);
            for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
                got_o[i] = line_i;
                repeat (BITC) @(posedge clk_i);
            end
            cnt_o++;
        end
    end

    // Talker idles high between frames
    // frame layout
    initial begin
        rxd_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (send_i) begin
                rxd_o <= 1'b0;
                repeat (BITC) @(posedge clk_i);
                for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                    rxd_o <= word_i[i];
                    repeat (BITC) @(posedge clk_i);
                end
                rxd_o <= 1'b1;
                repeat (BITC) @(posedge clk_i);
            end
        end
    end
endmodule

//--- ulf_tb_top.sv
`timescale 1ns/10ps
module ulf_tb_top;
    import ulf_pkg::*;
    localparam logic [7:0] MF [5] = '{8'h00, 8'h20, 8'h80, 8'hA0, 8'hA0}; // Mode table
    localparam logic [4:0] MD = 5'b10000;  // Direction per mode
    localparam logic [4:0] MO = 5'b10011;  // Expected pin enable
    localparam logic [7:0] TXF [6] = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
    logic       clk_i, sys_rst_i, wr_i, rd_i, cpu_wait_i;  // Clock, reset, strobes
    logic [3:0] addr_i;               // Register address
    logic [7:0] wdata_i, rdata_o, r;  // Bus data and scratch
    logic       txd_o, txd_oe_o, irq_o, rxd, send, nine;
    logic [8:0] word;                 // Word for the peer to send
    logic [9:0] got;                  // Frame seen by the peer
    int         gcnt, error_cnt, comparisons;
    wire        pin = txd_oe_o ? txd_o : 1'b1;  // Pull-up when released

    ulf_top uut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cpu_wait_i,
                 .rxd_i(rxd), .txd_pin_i(pin), .txd_o, .txd_oe_o, .irq_o);
    ulf_peer peer (.clk_i, .line_i(pin), .nine_i(nine), .send_i(send), .word_i(word),
                   .rxd_o(rxd), .got_o(got), .cnt_o(gcnt));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic results();
        $display("Mismatches %0d of %0d checks", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand one cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Bounded status wait; timeout ends the run
    task automatic poll(input int b);
        logic [7:0] s;
        for (int i = 0; i < 3000; i++) begin
            rd(ULF_OFS_STATUS, s);
            if (s[b] === 1'b1) return;
        end
        error_cnt++;
        results();
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && gcnt == n; i++) @(posedge clk_i);
        if (gcnt == n) begin
            error_cnt++;
            results();
        end
    endtask

    // Expected line bits: data LSB first, parity on top, stop
    function automatic logic [9:0] frame(logic [7:0] d, logic [7:0] f, logic t9);
        logic [8:0] b;
        b = {t9, d};
        if (f[ULF_B_PAR] && !f[ULF_B_NINE]) b[7] = ^d[6:0] ^ f[ULF_B_ODD];
        if (f[ULF_B_PAR] && f[ULF_B_NINE]) b[8] = ^d ^ f[ULF_B_ODD];
        return f[ULF_B_NINE] ? {1'b1, b} : {2'b01, b[7:0]};
    endfunction

    initial begin
        logic [7:0] d;
        logic       t9;
        int         n;
        {sys_rst_i, wr_i, rd_i, cpu_wait_i, send, nine} = 6'b100000;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        word = 9'h000;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(33));
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(ULF_OFS_STATUS, r);
        chk(10'(r[7:6]), 10'h003);
        rd(4'hF, r);
        chk(10'(r), 10'h000);
        rd(ULF_OFS_BAUD_LO, r);
        chk(10'(r), 10'h004);
        // Both flags idle high: each enable alone interrupts
        repeat (8) begin
            d = 8'($urandom) & 8'hC0;
            wr(ULF_OFS_IRQ_EN, d);
            rd(ULF_OFS_IRQ_EN, r);
            chk(10'(r & 8'hCC), 10'(d));
            rd(ULF_OFS_STATUS, r);
            chk(10'(irq_o), 10'(|d));
        end
        wr(ULF_OFS_BAUD_HI, 8'h00);
        wr(ULF_OFS_BAUD_LO, 8'h01);
        wr(ULF_OFS_IRQ_EN, 8'h0C);
        for (int i = 0; i < 5; i++) begin
            wr(ULF_OFS_LINE_FMT, MF[i]);
            wr(ULF_OFS_AUX, {7'h00, MD[i]});
            rd(ULF_OFS_LINE_FMT, r);
            chk(10'(r), 10'(MF[i]));
            chk(10'(txd_oe_o), 10'(MO[i]));
        end
        // Internal loop: char returns, peer sees nothing
        wr(ULF_OFS_LINE_FMT, 8'h80);
        n = gcnt;
        d = 8'($urandom);
        wr(ULF_OFS_DATA, d);
        poll(5);
        rd(ULF_OFS_DATA, r);
        chk(10'(r), 10'(d));
        chk(10'(gcnt), 10'(n));
        for (int i = 0; i < 6; i++) begin
            poll(6);
            nine <= TXF[i][ULF_B_NINE];
            t9 = 1'($urandom);
            d = 8'($urandom);
            wr(ULF_OFS_LINE_FMT, TXF[i]);
            wr(ULF_OFS_AUX, {6'h00, t9, 1'b0});
            n = gcnt;
            cpu_wait_i <= i[0];
            wr(ULF_OFS_DATA, d);
            wait_got(n);
            cpu_wait_i <= 1'b0;
            chk(got, frame(d, TXF[i], t9));
        end
        // Frozen mid-frame: pin watched, peer capture ignored
        poll(6);
        wr(ULF_OFS_LINE_FMT, 8'h40);
        wr(ULF_OFS_DATA, 8'h55);
        repeat (40) @(posedge clk_i);
        cpu_wait_i <= 1'b1;
        repeat (64) @(posedge clk_i);
        cpu_wait_i <= 1'b0;
        poll(6);
        repeat (400) @(posedge clk_i);
        wr(ULF_OFS_EVT_MASK, 8'h01);
        rd(ULF_OFS_EVT, r);
        chk(10'(r[ULF_E_TXDONE]), 10'h001);
        chk(10'(irq_o), 10'h001);
        wr(ULF_OFS_EVT_MASK, 8'h00);
        rd(ULF_OFS_EVT, r);
        chk(10'(irq_o), 10'h000);
        wr(ULF_OFS_EVT_MASK, 8'h01);
        wr(ULF_OFS_EVT, 8'h01);
        rd(ULF_OFS_EVT, r);
        chk(10'({r[ULF_E_TXDONE], irq_o}), 10'h000);
        // Received even parity: one good, one flipped
        wr(ULF_OFS_LINE_FMT, 8'h02);
        nine <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            d[7] = ^d[6:0] ^ i[0];
            word <= {1'b0, d};
            send <= 1'b1;
            @(posedge clk_i);
            send <= 1'b0;
            poll(5);
            rd(ULF_OFS_DATA, r);
            chk(10'(r[6:0]), 10'(d[6:0]));
            rd(ULF_OFS_EVT, r);
            chk(10'(r[ULF_E_PARITY]), 10'(i[0]));
            wr(ULF_OFS_EVT, 8'h04);
        end
        results();
    end
endmodule
